// >>> logic/slp_param_regs.sv
// How it works
// - capture lane 7 received checksum, read-only
// - expose locally computed lane 7 checksum, read-only
// - 8-bit bank id, resets to zero
// - lane-adjust direction at bit 6, subclass 2
// - phase-adjust request at bit 5, subclass 2
// - 5-bit lane 0 identifier, resets zero
// - descramble when enable bit set, resets 1
// - lane count minus one, reset 7, restricted
// - frames per multiframe minus one, reset 0x1f
`timescale 1ns/100ps
`default_nettype none
`include "slp_defines.svh"

module slp_param_regs (
   input wire logic ref_clk, // 250 MHz core clock
   input wire logic rst_n, // synchronous reset, active low
   input wire logic spiCsN, // serial port select pin, active low
   input wire logic spiSclk, // serial port clock pin
   input wire logic spiSdi, // serial port data in pin
   output logic spiSdo, // serial port data out
   output logic spiSdoOeN, // data out enable, low while driving
   input wire logic lane7IlasValid, // pulse: lane 7 alignment fields valid
   input wire logic [7:0] lane7RxSum, // checksum octet from lane 7
   input wire slp_pkg::slp_ilas_params_t lane7Params, // lane 7 fields
   input wire logic [4:0] laneCountM1In, // lane count from mode logic
   input wire logic [7:0] frameSizeCtrl, // frame size control register
   input wire logic [2:0] subclassSel, // active device subclass
   input wire logic [7:0] rxData, // received lane octet
   input wire logic rxValid, // received octet valid
   output logic [7:0] rxDataOut, // descrambled octet
   output logic rxValidOut, // descrambled octet valid
   output slp_pkg::slp_link_cfg_t linkCfg // expected link parameters
);

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   // index 0 means unmapped: reads give zero, writes are dropped
   function automatic logic [3:0] slp_decode(input logic [14:0] a);
      logic [3:0] idx;
      idx = 4'h0;
      case (a)
         `SLP_OFS_RX_SUM: idx = 4'h1;
         `SLP_OFS_CALC_SUM: idx = 4'h2;
         `SLP_OFS_DEV_ID: idx = 4'h3;
         `SLP_OFS_BANK_ID: idx = 4'h4;
         `SLP_OFS_LANE0: idx = 4'h5;
         `SLP_OFS_SCR_L: idx = 4'h6;
         `SLP_OFS_OCTETS: idx = 4'h7;
         `SLP_OFS_FRAMES: idx = 4'h8;
         default: idx = 4'h0;
      endcase
      return idx;
   endfunction : slp_decode

   // only 1, 2, 3, 4, 6 and 8 lanes exist
   function automatic logic slp_lanes_ok(input logic [4:0] m1);
      return (m1 <= 5'h03) || (m1 == 5'h05) || (m1 == 5'h07);
   endfunction : slp_lanes_ok

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [2:0] pinMeta_reg;
   logic [2:0] pinSync_reg;
   logic [2:0] pinLast_reg;
   logic [2:0] pinRaw;

   assign pinRaw = {spiCsN, spiSclk, spiSdi};

   // stage one feeds only stage two; edges use stages two and three
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++)
      begin : gSync
         always_ff @(posedge ref_clk)
         begin
            if (!rst_n)
            begin
               pinMeta_reg[gi] <= (gi != 1); // sclk idles low, no false edge
               pinSync_reg[gi] <= (gi != 1);
               pinLast_reg[gi] <= (gi != 1);
            end
            else
            begin
               pinMeta_reg[gi] <= pinRaw[gi];
               pinSync_reg[gi] <= pinMeta_reg[gi];
               pinLast_reg[gi] <= pinSync_reg[gi];
            end
         end
      end
   endgenerate

   logic csIdle;
   logic sdiS;
   logic sclkRise;
   logic sclkFall;

   assign csIdle = pinSync_reg[2];
   assign sdiS = pinSync_reg[0];
   assign sclkRise = pinSync_reg[1] & ~pinLast_reg[1];
   assign sclkFall = ~pinSync_reg[1] & pinLast_reg[1];

   // ----------------------------------------------------------------
   // serial port: 16-bit instruction (read flag, address), 8 data bits
   // ----------------------------------------------------------------
   slp_pkg::slp_spi_state_t state_reg;
   slp_pkg::slp_spi_state_t state_next;
   logic [3:0] bitCnt_reg;
   logic [3:0] bitCnt_next;
   logic [15:0] shiftIn_reg;
   logic [15:0] shiftIn_next;
   logic [14:0] addr_reg;
   logic [14:0] addr_next;
   logic read_reg;
   logic read_next;
   logic [7:0] shiftOut_reg;
   logic [7:0] shiftOut_next;
   logic sdo_reg;
   logic sdo_next;
   logic wrStb;
   logic [7:0] wrData;
   logic [14:0] instrAddr;
   logic [7:0] rdData;

   assign instrAddr = {shiftIn_reg[13:0], sdiS};

   // transfer sequencer; a select release aborts any partial frame
   always_comb
   begin
      state_next = state_reg;
      bitCnt_next = bitCnt_reg;
      shiftIn_next = shiftIn_reg;
      addr_next = addr_reg;
      read_next = read_reg;
      shiftOut_next = shiftOut_reg;
      sdo_next = sdo_reg;
      wrStb = 1'b0;
      wrData = {shiftIn_reg[6:0], sdiS};
      if (csIdle)
      begin
         state_next = slp_pkg::SPI_IDLE;
         bitCnt_next = 4'h0;
      end
      else
      begin
         case (state_reg)
            slp_pkg::SPI_IDLE:
            begin
               state_next = slp_pkg::SPI_INSTR;
               bitCnt_next = 4'h0;
               if (sclkRise)
               begin
                  shiftIn_next = {shiftIn_reg[14:0], sdiS};
                  bitCnt_next = 4'h1;
               end
            end
            slp_pkg::SPI_INSTR:
            begin
               if (sclkRise)
               begin
                  shiftIn_next = {shiftIn_reg[14:0], sdiS};
                  bitCnt_next = bitCnt_reg + 4'h1;
                  if (bitCnt_reg == `SLP_INSTR_LAST)
                  begin
                     read_next = shiftIn_reg[14];
                     addr_next = instrAddr;
                     shiftOut_next = rdData;
                     bitCnt_next = 4'h0;
                     state_next = slp_pkg::SPI_DATA;
                  end
               end
            end
            slp_pkg::SPI_DATA:
            begin
               if (sclkFall && read_reg)
               begin
                  sdo_next = shiftOut_reg[7];
                  shiftOut_next = {shiftOut_reg[6:0], 1'b0};
               end
               if (sclkRise)
               begin
                  shiftIn_next = {shiftIn_reg[14:0], sdiS};
                  bitCnt_next = bitCnt_reg + 4'h1;
                  if (bitCnt_reg == `SLP_DATA_LAST)
                  begin
                     wrStb = ~read_reg;
                     state_next = slp_pkg::SPI_DONE;
                  end
               end
            end
            slp_pkg::SPI_DONE:
            begin
               state_next = slp_pkg::SPI_DONE;
            end
            default:
            begin
               state_next = slp_pkg::SPI_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         state_reg <= slp_pkg::SPI_IDLE;
         bitCnt_reg <= 4'h0;
         shiftIn_reg <= 16'h0000;
         addr_reg <= 15'h0000;
         read_reg <= 1'b0;
         shiftOut_reg <= 8'h00;
         sdo_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         bitCnt_reg <= bitCnt_next;
         shiftIn_reg <= shiftIn_next;
         addr_reg <= addr_next;
         read_reg <= read_next;
         shiftOut_reg <= shiftOut_next;
         sdo_reg <= sdo_next;
      end
   end

   assign spiSdo = sdo_reg;
   assign spiSdoOeN = ~((state_reg == slp_pkg::SPI_DATA) && read_reg && !csIdle);

   // ----------------------------------------------------------------
   // register bank
   // ----------------------------------------------------------------
   logic [7:0] rxSum_reg, rxSum_next;
   logic [7:0] calcSum_reg, calcSum_next;
   logic [7:0] devId_reg, devId_next;
   logic [7:0] bankId_reg, bankId_next;
   logic [6:0] lane0_reg, lane0_next;
   logic scr_reg, scr_next;
   logic [4:0] lanes_reg, lanes_next;
   logic [7:0] octets_reg, octets_next;
   logic [4:0] frames_reg, frames_next;
   logic ilasValidD_reg;
   logic [7:0] localSum;

   slp_checksum uChecksum (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .params(lane7Params),
      .sum(localSum)
   );

   // writes reach only the writable fields; status captures stay live
   // because the link may finish alignment while software is idle
   always_comb
   begin
      rxSum_next = rxSum_reg;
      calcSum_next = calcSum_reg;
      devId_next = devId_reg;
      bankId_next = bankId_reg;
      lane0_next = lane0_reg;
      scr_next = scr_reg;
      lanes_next = lanes_reg;
      octets_next = frameSizeCtrl;
      frames_next = frames_reg;
      if (lane7IlasValid)
      begin
         rxSum_next = lane7RxSum;
      end
      if (ilasValidD_reg)
      begin
         calcSum_next = localSum;
      end
      if (slp_lanes_ok(laneCountM1In))
      begin
         lanes_next = laneCountM1In;
      end
      // no soft reset check here: software keeps that discipline
      if (wrStb)
      begin
         case (slp_decode(addr_reg))
            4'h3: devId_next = wrData;
            4'h4: bankId_next = wrData;
            4'h5: lane0_next = wrData[6:0];
            4'h6: scr_next = wrData[`SLP_SCR_BIT];
            4'h8: frames_next = wrData[4:0];
            default: lane0_next = lane0_reg;
         endcase
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         rxSum_reg <= `SLP_RST_SUM;
         calcSum_reg <= `SLP_RST_SUM;
         devId_reg <= `SLP_RST_DEV_ID;
         bankId_reg <= `SLP_RST_BANK_ID;
         lane0_reg <= `SLP_RST_LANE0;
         scr_reg <= `SLP_RST_SCR;
         lanes_reg <= `SLP_RST_LANES;
         octets_reg <= `SLP_RST_OCTETS;
         frames_reg <= `SLP_RST_FRAMES;
         ilasValidD_reg <= 1'b0;
      end
      else
      begin
         rxSum_reg <= rxSum_next;
         calcSum_reg <= calcSum_next;
         devId_reg <= devId_next;
         bankId_reg <= bankId_next;
         lane0_reg <= lane0_next;
         scr_reg <= scr_next;
         lanes_reg <= lanes_next;
         octets_reg <= octets_next;
         frames_reg <= frames_next;
         ilasValidD_reg <= lane7IlasValid;
      end
   end

   // read view; reserved bits read as zero
   always_comb
   begin
      case (slp_decode(instrAddr))
         4'h1: rdData = rxSum_reg;
         4'h2: rdData = calcSum_reg;
         4'h3: rdData = devId_reg;
         4'h4: rdData = bankId_reg;
         4'h5: rdData = {1'b0, lane0_reg};
         4'h6: rdData = {scr_reg, 2'b00, lanes_reg};
         4'h7: rdData = octets_reg;
         4'h8: rdData = {3'b000, frames_reg};
         default: rdData = 8'h00;
      endcase
   end

   // ----------------------------------------------------------------
   // configuration to the link receiver
   // ----------------------------------------------------------------
   logic sub2;

   assign sub2 = (subclassSel == `SLP_SUBCLASS2);

   // adjust bits mean nothing outside subclass 2, so they are masked
   always_comb
   begin
      linkCfg.deviceId = devId_reg;
      linkCfg.bankId = bankId_reg;
      linkCfg.lane0Id = lane0_reg[4:0];
      linkCfg.adjDir = lane0_reg[`SLP_ADJDIR_BIT] & sub2;
      linkCfg.phAdj = lane0_reg[`SLP_PHADJ_BIT] & sub2;
      linkCfg.descrambleEn = scr_reg;
      linkCfg.laneCountM1 = lanes_reg;
      linkCfg.octetsM1 = frameSizeCtrl;
      linkCfg.framesM1 = frames_reg;
   end

   // ----------------------------------------------------------------
   // descrambler, polynomial 1 + x^14 + x^15, msb first
   // ----------------------------------------------------------------
   logic [14:0] hist_reg, hist_next;
   logic [7:0] desc_reg, desc_next;
   logic descValid_reg;

   // history always tracks scrambled bits so toggling the enable
   // does not need a resync period
   always_comb
   begin
      logic [14:0] h;
      h = hist_reg;
      desc_next = desc_reg;
      if (rxValid)
      begin
         for (int i = 7; i >= 0; i--)
         begin
            desc_next[i] = scr_reg ? (rxData[i] ^ h[13] ^ h[14]) : rxData[i];
            h = {h[13:0], rxData[i]};
         end
      end
      hist_next = h;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         hist_reg <= 15'h0000;
         desc_reg <= 8'h00;
         descValid_reg <= 1'b0;
      end
      else
      begin
         hist_reg <= hist_next;
         desc_reg <= desc_next;
         descValid_reg <= rxValid;
      end
   end

   assign rxDataOut = desc_reg;
   assign rxValidOut = descValid_reg;

endmodule : slp_param_regs

`default_nettype wire

// >>> logic/slp_defines.svh
`ifndef SLP_DEFINES_SVH
`define SLP_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets (15-bit serial port address)
// ----------------------------------------------------------------
`define SLP_OFS_RX_SUM 15'h0445
`define SLP_OFS_CALC_SUM 15'h0446
`define SLP_OFS_DEV_ID 15'h0450
`define SLP_OFS_BANK_ID 15'h0451
`define SLP_OFS_LANE0 15'h0452
`define SLP_OFS_SCR_L 15'h0453
`define SLP_OFS_OCTETS 15'h0454
`define SLP_OFS_FRAMES 15'h0455

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SLP_ADJDIR_BIT 6
`define SLP_PHADJ_BIT 5
`define SLP_SCR_BIT 7

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SLP_RST_SUM 8'h00
`define SLP_RST_DEV_ID 8'h00
`define SLP_RST_BANK_ID 8'h00
`define SLP_RST_LANE0 7'h00
`define SLP_RST_SCR 1'b1
`define SLP_RST_LANES 5'h07
`define SLP_RST_OCTETS 8'h00
`define SLP_RST_FRAMES 5'h1f

// ----------------------------------------------------------------
// serial port framing and misc codes
// ----------------------------------------------------------------
`define SLP_INSTR_LAST 4'hf
`define SLP_DATA_LAST 4'h7
`define SLP_SUBCLASS2 3'h2

`endif

// >>> logic/slp_pkg.sv
package slp_pkg;

   // serial port transfer phases
   typedef enum logic [1:0] {
      SPI_IDLE = 2'b00,
      SPI_INSTR = 2'b01,
      SPI_DATA = 2'b10,
      SPI_DONE = 2'b11
   } slp_spi_state_t;

   // configuration fields received in the alignment sequence of one lane
   typedef struct packed {
      logic [7:0] did;
      logic [3:0] bid;
      logic [3:0] adjCnt;
      logic [4:0] lid;
      logic phAdj;
      logic adjDir;
      logic [4:0] lanes;
      logic scr;
      logic [7:0] octets;
      logic [4:0] frames;
      logic [7:0] conv;
      logic [4:0] res;
      logic [1:0] ctrlBits;
      logic [4:0] bitsPerSample;
      logic [2:0] subclass;
      logic [4:0] samples;
      logic [2:0] version;
      logic [4:0] ctrlWords;
      logic highDensity;
   } slp_ilas_params_t;

   // expected link parameters handed to the link receiver
   typedef struct packed {
      logic [7:0] deviceId;
      logic [7:0] bankId;
      logic [4:0] lane0Id;
      logic adjDir;
      logic phAdj;
      logic descrambleEn;
      logic [4:0] laneCountM1;
      logic [7:0] octetsM1;
      logic [4:0] framesM1;
   } slp_link_cfg_t;

endpackage : slp_pkg

// >>> logic/slp_checksum.sv
`timescale 1ns/100ps
`default_nettype none

module slp_checksum (
   input wire logic ref_clk, // core clock
   input wire logic rst_n, // synchronous reset, active low
   input wire slp_pkg::slp_ilas_params_t params, // received lane fields
   output logic [7:0] sum // registered modulo-256 sum
);

   logic [7:0] sum_reg;
   logic [7:0] sum_next;

   // ----------------------------------------------------------------
   // field sum
   // ----------------------------------------------------------------
   // field values, not packed octets, are summed; carries drop off
   always_comb
   begin
      sum_next = 8'(params.did) + 8'(params.bid) + 8'(params.adjCnt)
         + 8'(params.lid) + 8'(params.phAdj) + 8'(params.adjDir)
         + 8'(params.lanes) + 8'(params.scr) + 8'(params.octets)
         + 8'(params.frames) + 8'(params.conv) + 8'(params.res)
         + 8'(params.ctrlBits) + 8'(params.bitsPerSample)
         + 8'(params.subclass) + 8'(params.samples)
         + 8'(params.version) + 8'(params.ctrlWords)
         + 8'(params.highDensity);
   end

   // register the sum to break the long adder path
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         sum_reg <= 8'h00;
      end
      else
      begin
         sum_reg <= sum_next;
      end
   end

   assign sum = sum_reg;

endmodule : slp_checksum

`default_nettype wire

// >>> tb/slp_param_regs_asserts.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// port checks for the link parameter registers
// ----------------------------------------------------------------
module slp_param_regs_asserts (
   input wire logic ref_clk, // core clock
   input wire logic rst_n, // sync reset, active low
   input wire logic spiCsN, // serial select, active low
   input wire logic spiSclk, // serial clock
   input wire logic spiSdi, // serial data in
   input wire logic spiSdo, // serial data out
   input wire logic spiSdoOeN, // data out enable, active low
   input wire logic lane7IlasValid, // alignment fields valid
   input wire logic [7:0] lane7RxSum, // received checksum
   input wire slp_pkg::slp_ilas_params_t lane7Params, // lane 7 fields
   input wire logic [4:0] laneCountM1In, // lane count from mode logic
   input wire logic [7:0] frameSizeCtrl, // frame size control
   input wire logic [2:0] subclassSel, // active subclass
   input wire logic [7:0] rxData, // received octet
   input wire logic rxValid, // received octet valid
   input wire logic [7:0] rxDataOut, // descrambled octet
   input wire logic rxValidOut, // descrambled valid
   input wire slp_pkg::slp_link_cfg_t linkCfg // expected link parameters
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   // disabled descrambler hands the octet through untouched
   property p_pass; rxValid && !linkCfg.descrambleEn
      |=> rxValidOut && rxDataOut == $past(rxData); endproperty
   a_pass: assert property (p_pass) else $error("pass-through octet wrong");
   property p_lat; 1'b1 |=> rxValidOut == $past(rxValid); endproperty
   a_lat: assert property (p_lat) else $error("octet valid latency wrong");
   property p_oct; linkCfg.octetsM1 == frameSizeCtrl; endproperty
   a_oct: assert property (p_oct) else $error("frame size not from control");
   property p_legal;
      linkCfg.laneCountM1 inside {5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h07}; endproperty
   a_legal: assert property (p_legal) else $error("illegal lane count");
   // an illegal code must not disturb the held count
   property p_lhold;
      !(laneCountM1In inside {5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h07}) [*2]
      |=> $stable(linkCfg.laneCountM1); endproperty
   a_lhold: assert property (p_lhold) else $error("lane count took bad code");
   property p_sub; subclassSel != 3'h2 |-> !linkCfg.adjDir && !linkCfg.phAdj; endproperty
   a_sub: assert property (p_sub) else $error("adjust bits outside subclass 2");
   // with no serial frame nothing may move the written fields
   property p_hold; spiCsN [*8] |=> $stable({linkCfg.deviceId, linkCfg.bankId,
      linkCfg.lane0Id, linkCfg.descrambleEn, linkCfg.framesM1}); endproperty
   a_hold: assert property (p_hold) else $error("idle field moved");
   property p_sdo; spiCsN [*4] |-> spiSdoOeN; endproperty
   a_sdo: assert property (p_sdo) else $error("data out driven while idle");
   property p_rst; disable iff (1'b0) !rst_n ##1 !rst_n |-> linkCfg.framesM1 == 5'h1f
      && linkCfg.descrambleEn && linkCfg.laneCountM1 == 5'h07 && linkCfg.bankId == 8'h00
      && linkCfg.lane0Id == 5'h00 && !rxValidOut; endproperty
   a_rst: assert property (p_rst)
      else $error("reset values wrong");
endmodule : slp_param_regs_asserts

bind slp_param_regs slp_param_regs_asserts u_chk (.ref_clk, .rst_n, .spiCsN, .spiSclk,
   .spiSdi, .spiSdo, .spiSdoOeN, .lane7IlasValid, .lane7RxSum, .lane7Params,
   .laneCountM1In, .frameSizeCtrl, .subclassSel, .rxData, .rxValid, .rxDataOut,
   .rxValidOut, .linkCfg);
`default_nettype wire

// >>> tb/slp_tx_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// link transmitter model for lane 7
// ----------------------------------------------------------------
module slp_tx_model (
   input wire logic ref_clk, // core clock
   input wire logic rst_n, // sync reset, active low
   input wire logic ilasReq, // send one alignment sequence
   input wire slp_pkg::slp_ilas_params_t ilasFields, // fields to send
   input wire logic [7:0] ilasSum, // checksum octet to send
   input wire logic dataReq, // send one octet
   input wire logic [7:0] dataByte, // octet to send
   output logic lane7IlasValid, // fields valid pulse
   output logic [7:0] lane7RxSum, // checksum octet
   output slp_pkg::slp_ilas_params_t lane7Params, // lane fields
   output logic [7:0] rxData, // lane octet
   output logic rxValid // octet valid
);
   logic armed;

   // quiet lane before the first transfer
   initial
   begin
      armed = 1'b0;
      lane7IlasValid = 1'b0;
      lane7RxSum = 8'h00;
      lane7Params = '0;
      rxData = 8'h00;
      rxValid = 1'b0;
   end

   // fields stand a cycle ahead of the pulse, then are spoilt so stale
   // values can never pass for a fresh capture
   always @(posedge ref_clk)
   begin
      rxValid <= dataReq && rst_n;
      rxData <= dataReq ? dataByte : ~rxData;
      armed <= ilasReq && rst_n;
      lane7IlasValid <= armed;
      if (ilasReq)
      begin
         lane7Params <= ilasFields;
         lane7RxSum <= ilasSum;
      end
      else if (lane7IlasValid)
      begin
         lane7Params <= ~lane7Params;
         lane7RxSum <= ~lane7RxSum;
      end
   end
endmodule : slp_tx_model
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// self-checking bench for the link parameter registers
// ----------------------------------------------------------------
module tb;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic spiCsN = 1'b1, spiSclk = 1'b0, spiSdi = 1'b0, spiSdo, spiSdoOeN;
   logic lane7IlasValid, rxValid, rxValidOut, rdStb = 1'b0;
   logic ilasReq = 1'b0, dataReq = 1'b0;
   logic [7:0] lane7RxSum, rxData, rxDataOut, rdVal, ilasSum = 8'h00, dataByte = 8'h00;
   logic [7:0] frameSizeCtrl = 8'h03;
   logic [4:0] laneCountM1In = 5'h03, e;
   logic [2:0] subclassSel = 3'h2;
   slp_pkg::slp_ilas_params_t lane7Params, ilasFields = '0;
   slp_pkg::slp_link_cfg_t linkCfg;
   logic [95:0] r;
   logic [14:0] hist = 15'h0000;
   logic [8:0] q, dsQ[$];
   logic [7:0] rdQ[$], w[5];
   logic [14:0] wa[5] = '{15'h0450, 15'h0451, 15'h0452, 15'h0453, 15'h0455};
   logic [7:0] wm[5] = '{8'hff, 8'hff, 8'h7f, 8'h80, 8'h1f};
   int miscompares = 0, checked = 0, cyc = 0, nData = 0;

   always #2 ref_clk = ~ref_clk;

   slp_param_regs uut (.ref_clk, .rst_n, .spiCsN, .spiSclk, .spiSdi, .spiSdo, .spiSdoOeN,
      .lane7IlasValid, .lane7RxSum, .lane7Params, .laneCountM1In, .frameSizeCtrl,
      .subclassSel, .rxData, .rxValid, .rxDataOut, .rxValidOut, .linkCfg);
   slp_tx_model tx (.ref_clk, .rst_n, .ilasReq, .ilasFields, .ilasSum, .dataReq,
      .dataByte, .lane7IlasValid, .lane7RxSum, .lane7Params, .rxData, .rxValid);

   task automatic test_done;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : test_done

   task automatic chk(logic [7:0] got, logic [7:0] exp);
      checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wt(int n);
      repeat (n) @(negedge ref_clk);
   endtask : wt

   // one frame, sclk levels of 6 cycles so the synchronisers keep up
   task automatic spi(logic rd, logic [14:0] a, logic [7:0] d);
      logic [23:0] f;
      logic [7:0] b;
      f = {rd, a, d};
      spiCsN = 1'b0;
      wt(4);
      for (int i = 0; i < 24; i++)
      begin
         spiSclk = 1'b0;
         spiSdi = f[23 - i];
         wt(6);
         b = {b[6:0], spiSdo};
         if (i > 15 && rd)
            chk({7'h00, spiSdoOeN}, 8'h00);
         spiSclk = 1'b1;
         wt(6);
      end
      wt(4);
      spiSclk = 1'b0;
      spiCsN = 1'b1;
      wt(6);
      if (rd)
      begin
         rdVal = b;
         rdStb = 1'b1;
         wt(1);
         rdStb = 1'b0;
      end
   endtask : spi

   task automatic rd(logic [14:0] a, logic [7:0] x);
      rdQ.push_back(x);
      spi(1'b1, a, 8'h00);
   endtask : rd

   // history moves on every octet, enabled or not
   task automatic send(logic [7:0] b, logic en);
      logic [7:0] o;
      for (int j = 7; j >= 0; j--)
      begin
         o[j] = b[j] ^ hist[13] ^ hist[14];
         hist = {hist[13:0], b[j]};
      end
      dsQ.push_back({nData > 1, en ? o : b});
      nData++;
      dataByte = b;
      dataReq = 1'b1;
      wt(1);
   endtask : send

   function automatic logic [7:0] fsum(slp_pkg::slp_ilas_params_t p);
      return p.did + p.bid + p.adjCnt + p.lid + p.phAdj + p.adjDir + p.lanes + p.scr
         + p.octets + p.frames + p.conv + p.res + p.ctrlBits + p.bitsPerSample
         + p.subclass + p.samples + p.version + p.ctrlWords + p.highDensity;
   endfunction : fsum

   // results taken in order; first octets wait for a full history
   always @(posedge ref_clk)
   begin
      if (rdStb)
         chk(rdVal, rdQ.pop_front());
      if (rxValidOut)
      begin
         q = dsQ.size() > 0 ? dsQ.pop_front() : {1'b1, ~rxDataOut};
         if (q[8])
            chk(rxDataOut, q[7:0]);
      end
   end

   // cut a hang short well above the expected run length
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         miscompares++;
         test_done;
      end
   end

   // main sequence
   initial
   begin
      void'($urandom(18849));
      wt(3);
      rst_n = 1'b1;
      wt(4);
      rd(15'h0445, 8'h00);
      rd(15'h0446, 8'h00);
      rd(15'h0451, 8'h00);
      rd(15'h0452, 8'h00);
      rd(15'h0453, 8'h83);
      rd(15'h0455, 8'h1f);
      rd(15'h0460, 8'h00);
      frameSizeCtrl = 8'($urandom);
      wt(2);
      chk(linkCfg.octetsM1, frameSizeCtrl);
      rd(15'h0454, frameSizeCtrl);
      $display("reset values done");
      for (int k = 0; k < 2; k++)
      begin
         r = {$urandom, $urandom, $urandom};
         ilasFields = r[78:0];
         ilasSum = fsum(ilasFields) ^ (k ? 8'h5a : 8'h00);
         ilasReq = 1'b1;
         wt(1);
         ilasReq = 1'b0;
         wt(4);
         rd(15'h0445, ilasSum);
         rd(15'h0446, fsum(ilasFields));
      end
      $display("checksum capture done");
      for (int k = 0; k < 5; k++)
      begin
         w[k] = k == 0 ? ilasFields.did : (k == 4 ? 8'hef : 8'($urandom));
         spi(1'b0, wa[k], w[k]);
         rd(wa[k], w[k] & wm[k] | (k == 3 ? 8'h03 : 8'h00));
      end
      chk(linkCfg.deviceId, w[0]);
      chk(linkCfg.bankId, w[1]);
      chk({linkCfg.adjDir, linkCfg.phAdj, linkCfg.lane0Id}, w[2][6:0]);
      chk(linkCfg.descrambleEn, w[3][7]);
      chk(linkCfg.framesM1, 8'h0f);
      subclassSel = 3'h1;
      wt(2);
      chk({linkCfg.adjDir, linkCfg.phAdj}, 8'h00);
      for (int k = 0; k < 3; k++)
         spi(1'b0, k == 2 ? 15'h0454 : 15'h0445 + 15'(k), 8'hff);
      rd(15'h0445, ilasSum);
      rd(15'h0446, fsum(ilasFields));
      rd(15'h0454, frameSizeCtrl);
      $display("register access done");
      e = 5'h03;
      for (int k = 0; k < 10; k++)
      begin
         laneCountM1In = 5'(k);
         if (k inside {0, 1, 2, 3, 5, 7})
            e = 5'(k);
         wt(3);
         chk(linkCfg.laneCountM1, e);
      end
      rd(15'h0453, {w[3][7], 7'h07});
      $display("lane count done");
      for (int m = 1; m >= 0; m--)
      begin
         spi(1'b0, 15'h0453, {m[0], 7'h00});
         for (int k = 0; k < 20; k++)
            send(8'($urandom), m[0]);
         dataReq = 1'b0;
         wt(4);
      end
      chk(8'(dsQ.size()), 8'h00);
      $display("descrambler done");
      test_done;
   end
endmodule : tb
`default_nettype wire
